// ### verilog/fbs_defs.svh
`ifndef FBS_DEFS_SVH
`define FBS_DEFS_SVH

// ==========================================================
// function and exception codes
`define FBS_FN_READ_HOLD 8'h03
`define FBS_FN_WRITE_ONE 8'h06
`define FBS_FN_EXC_BIT 8'h80
`define FBS_EXC_NONE 8'h00
`define FBS_EXC_FUNC 8'h01
`define FBS_EXC_ADDR 8'h02
`define FBS_EXC_DATA 8'h03
`define FBS_EXC_EXEC 8'h04

// ==========================================================
// parameter map (register addresses on the serial link)
`define FBS_PAR_FIRST 16'h0909
`define FBS_PAR_DELAY 16'h0909
`define FBS_PAR_FREQ 16'h090a
`define FBS_PAR_SLOT0 16'h090b
`define FBS_PAR_SLOT15 16'h091a
`define FBS_PAR_DEC_METH 16'h091b
`define FBS_PAR_PLC_MASK 16'h091c
`define FBS_PAR_CO_SPEED 16'h091d
`define FBS_PAR_CO_WARN 16'h091e
`define FBS_PAR_CO_DEC 16'h091f
`define FBS_PAR_CO_NET 16'h0920
`define FBS_PAR_CO_PROF 16'h0921
`define FBS_PAR_CO_RSTMSK 16'h0922
`define FBS_PAR_DN_SPEED 16'h0923
`define FBS_PAR_DN_EXT 16'h0924
`define FBS_PAR_LAST 16'h0924
`define FBS_SLOTS 16
`define FBS_MAX_READ 16'h0010

// control windows, frequency command at window offset 01
`define FBS_WIN1_HI 8'h20
`define FBS_WIN2_HI 8'h60
`define FBS_WIN_FREQ 8'h01

// ==========================================================
// reset values and limits
`define FBS_RST_DELAY 16'h0014
`define FBS_RST_FREQ 16'h1770
`define FBS_RST_DEC_METH 16'h0001
`define FBS_RST_CO_DEC 16'h0001
`define FBS_RST_RSTMSK 16'hffff
`define FBS_RST_DN_SPEED 16'h0002
`define FBS_MAX_DELAY 16'h07d0
`define FBS_MAX_FREQ 16'he9fc
`define FBS_MAX_CO_SPEED 16'h0005
`define FBS_MAX_DN_STD 16'h0003
`define FBS_MAX_DN_EXT 16'h0008

// ==========================================================
// timing: one delay step and the clock period
`define FBS_STEP_NS 100000
`define FBS_CLK_NS 4

`endif

// ### verilog/fbs_pkg.sv
package fbs_pkg;

	// gray path idle -> wait -> send
	typedef enum logic [1:0] {
		FBS_IDLE = 2'b00,
		FBS_WAIT = 2'b01,
		FBS_SEND = 2'b11
	} fbs_state_t;

	typedef enum logic [1:0] {
		FBS_TAIL_BODY = 2'b00,
		FBS_TAIL_CRCLO = 2'b01,
		FBS_TAIL_FINAL = 2'b11
	} fbs_tail_t;

endpackage

// ### verilog/fbs_frame_chk.sv
`timescale 1ns/10ps
module fbs_frame_chk
	import fbs_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	input wire logic clr_i,
	input wire logic en_i,
	input wire logic [7:0] byte_i,
	output logic [15:0] crc_q_o,
	output logic [15:0] crc_n_o,
	output logic [7:0] lrc_n_o
);

	logic [7:0] sum_reg;
	logic [15:0] c;

	// ==========================================================
	// crc-16 reflected, init all ones; lrc is negated byte sum
	always_comb begin
		c = crc_q_o ^ {8'h00, byte_i};
		for (int b = 0; b < 8; b++) begin
			if (c[0]) begin
				c = {1'b0, c[15:1]} ^ 16'ha001;
			end else begin
				c = {1'b0, c[15:1]};
			end
		end
		crc_n_o = c;
		lrc_n_o = 8'(8'h00 - 8'(sum_reg + byte_i));
	end

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			crc_q_o <= 16'hffff;
			sum_reg <= 8'h00;
		end else if (clr_i) begin
			crc_q_o <= 16'hffff;
			sum_reg <= 8'h00;
		end else if (en_i) begin
			crc_q_o <= crc_n_o;
			sum_reg <= 8'(sum_reg + byte_i);
		end
	end

endmodule

// ### verilog/fbs_comm.sv
// Summary of operation
// - unserved request answered with function code bit 7 set, then code
// - exception one for an unsupported function code
// - exception two for an unsupported register address
// - exception three for an out-of-range data value
// - exception four when a known function cannot be executed
// - reply starts after a programmable delay, 0.1 ms steps, default 2.0 ms
// - last serial frequency command kept over power loss and reused
// - serial frequency write updates the stored frequency setting
// - sixteen 16-bit block slots, read as a group with function 03H
// - decoding method picks window 20xxh or 60xxh for link control
// - keypad, terminal and plc control ignore the decoding method
// - before each plc scan, mask bits clear frequency, torque, limit
// - canopen rate code 0..5 gives 1M, 500k, 250k, 125k, 100k, 50k
// - canopen warnings kept as separate sticky bits 0,1,3,4,5,6
// - read-only canopen network state, codes 0 to 5
// - read-only drive profile state, codes 0-4, 7, 13, 14
// - canopen reset clears register groups chosen by mask bits 0..3
// - canopen decoding: 0 vendor command set, 1 standard profile
// - devicenet rate codes, standard 0..3, extended 0..8
`timescale 1ns/10ps
`include "fbs_defs.svh"
module fbs_comm
	import fbs_pkg::*;
#(
	parameter int STEP_CYC = `FBS_STEP_NS / `FBS_CLK_NS
)
(
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	input wire logic rtu_mode_i,
	input wire logic req_valid_i,
	input wire logic [7:0] req_slave_i,
	input wire logic [7:0] req_func_i,
	input wire logic [15:0] req_addr_i,
	input wire logic [15:0] req_data_i,
	input wire logic req_exec_fail_i,
	output logic req_ready_o,
	output logic tx_valid_o,
	output logic [7:0] tx_byte_o,
	output logic tx_last_o,
	input wire logic tx_ready_i,
	input wire logic freq_src_serial_i,
	input wire logic nv_load_i,
	input wire logic [15:0] nv_freq_i,
	output logic [15:0] comm_freq_o,
	output logic ctrl_valid_o,
	output logic [7:0] ctrl_index_o,
	output logic [15:0] ctrl_data_o,
	input wire logic plc_scan_start_i,
	output logic plc_clr_freq_o,
	output logic plc_clr_torque_o,
	output logic plc_clr_limit_o,
	input wire logic [6:0] co_warn_evt_i,
	input wire logic co_warn_clr_i,
	input wire logic [2:0] co_net_state_i,
	input wire logic [3:0] co_prof_state_i,
	input wire logic co_reset_i,
	output logic [3:0] co_grp_clear_o,
	output logic co_std_profile_o,
	output logic [9:0] co_rate_kbps_o,
	output logic [9:0] dn_rate_kbps_o,
	output logic [7:0] comm_error_display_o
);

	fbs_state_t state_reg;
	fbs_tail_t tail_reg;
	logic [15:0] delay_reg, freq_reg, dec_meth_reg, plc_mask_reg;
	logic [15:0] co_speed_reg, co_warn_reg, co_dec_reg, co_net_reg;
	logic [15:0] co_prof_reg, co_rstmsk_reg, dn_speed_reg, dn_ext_reg;
	logic [15:0] slot_reg [`FBS_SLOTS];
	logic [7:0] rsp_slave_reg, rsp_func_reg, rsp_exc_reg;
	logic [15:0] rsp_base_reg, rsp_data_reg, rsp_cnt_reg;
	logic [5:0] idx_reg, plen_reg;
	logic [15:0] step_cnt_reg, tick_cnt_reg;
	logic [7:0] exc_next;
	logic take, accept, win_hit, par_hit, wr_ok;
	logic [16:0] rd_end;
	logic [15:0] crc_q, crc_n;
	logic [7:0] lrc_n;

	assign take = req_valid_i && req_ready_o;
	assign accept = tx_valid_o && tx_ready_i;

	// ==========================================================
	// parameter read mux, holes and unknown addresses read zero
	function automatic logic [15:0] rd_par(input logic [15:0] a);
		logic [15:0] v;
		v = 16'h0000;
		if (a >= `FBS_PAR_SLOT0 && a <= `FBS_PAR_SLOT15) begin
			v = slot_reg[4'(a - `FBS_PAR_SLOT0)];
		end else begin
			unique case (a)
				`FBS_PAR_DELAY: v = delay_reg;
				`FBS_PAR_FREQ: v = freq_reg;
				`FBS_PAR_DEC_METH: v = dec_meth_reg;
				`FBS_PAR_PLC_MASK: v = plc_mask_reg;
				`FBS_PAR_CO_SPEED: v = co_speed_reg;
				`FBS_PAR_CO_WARN: v = co_warn_reg;
				`FBS_PAR_CO_DEC: v = co_dec_reg;
				`FBS_PAR_CO_NET: v = co_net_reg;
				`FBS_PAR_CO_PROF: v = co_prof_reg;
				`FBS_PAR_CO_RSTMSK: v = co_rstmsk_reg;
				`FBS_PAR_DN_SPEED: v = dn_speed_reg;
				`FBS_PAR_DN_EXT: v = dn_ext_reg;
				default: v = 16'h0000;
			endcase
		end
		return v;
	endfunction

	// ==========================================================
	// request check
	always_comb begin
		exc_next = `FBS_EXC_NONE;
		rd_end = 17'(req_addr_i) + 17'(req_data_i) - 17'h00001;
		// only link and card control passes the window
		win_hit = (req_addr_i[15:8] == (dec_meth_reg[0] ?
			`FBS_WIN2_HI : `FBS_WIN1_HI));
		par_hit = req_addr_i >= `FBS_PAR_FIRST &&
			req_addr_i <= `FBS_PAR_LAST;
		if (req_func_i != `FBS_FN_READ_HOLD &&
			req_func_i != `FBS_FN_WRITE_ONE) begin
			exc_next = `FBS_EXC_FUNC;
		end else if (req_func_i == `FBS_FN_READ_HOLD) begin
			if (req_data_i == 16'h0000 || req_data_i > `FBS_MAX_READ) begin
				exc_next = `FBS_EXC_DATA;
			end else if (!par_hit || rd_end > 17'(`FBS_PAR_LAST)) begin
				exc_next = `FBS_EXC_ADDR;
			end
		end else if (win_hit) begin
			if (req_addr_i[7:0] == `FBS_WIN_FREQ &&
				req_data_i > `FBS_MAX_FREQ) begin
				exc_next = `FBS_EXC_DATA;
			end
		end else if (!par_hit) begin
			exc_next = `FBS_EXC_ADDR;
		end else begin
			unique case (req_addr_i)
				`FBS_PAR_CO_WARN, `FBS_PAR_CO_NET, `FBS_PAR_CO_PROF:
					exc_next = `FBS_EXC_EXEC;
				`FBS_PAR_DELAY:
					if (req_data_i > `FBS_MAX_DELAY) exc_next = `FBS_EXC_DATA;
				`FBS_PAR_FREQ:
					if (req_data_i > `FBS_MAX_FREQ) exc_next = `FBS_EXC_DATA;
				`FBS_PAR_DEC_METH, `FBS_PAR_CO_DEC, `FBS_PAR_DN_EXT:
					if (req_data_i > 16'h0001) exc_next = `FBS_EXC_DATA;
				`FBS_PAR_CO_SPEED:
					if (req_data_i > `FBS_MAX_CO_SPEED) begin
						exc_next = `FBS_EXC_DATA;
					end
				`FBS_PAR_DN_SPEED:
					if (req_data_i > (dn_ext_reg[0] ?
						`FBS_MAX_DN_EXT : `FBS_MAX_DN_STD)) begin
						exc_next = `FBS_EXC_DATA;
					end
				default: exc_next = `FBS_EXC_NONE;
			endcase
		end
		if (exc_next == `FBS_EXC_NONE && req_exec_fail_i) begin
			exc_next = `FBS_EXC_EXEC;
		end
		wr_ok = take && req_func_i == `FBS_FN_WRITE_ONE &&
			exc_next == `FBS_EXC_NONE;
	end

	// ==========================================================
	// writable parameters
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			delay_reg <= `FBS_RST_DELAY;
			dec_meth_reg <= `FBS_RST_DEC_METH;
			plc_mask_reg <= 16'h0000;
			co_speed_reg <= 16'h0000;
			co_dec_reg <= `FBS_RST_CO_DEC;
			co_rstmsk_reg <= `FBS_RST_RSTMSK;
			dn_speed_reg <= `FBS_RST_DN_SPEED;
			dn_ext_reg <= 16'h0000;
		end else if (wr_ok && par_hit) begin
			unique case (req_addr_i)
				`FBS_PAR_DELAY: delay_reg <= req_data_i;
				`FBS_PAR_DEC_METH: dec_meth_reg <= req_data_i;
				`FBS_PAR_PLC_MASK: plc_mask_reg <= req_data_i;
				`FBS_PAR_CO_SPEED: co_speed_reg <= req_data_i;
				`FBS_PAR_CO_DEC: co_dec_reg <= req_data_i;
				`FBS_PAR_CO_RSTMSK: co_rstmsk_reg <= req_data_i;
				`FBS_PAR_DN_SPEED: dn_speed_reg <= req_data_i;
				`FBS_PAR_DN_EXT: dn_ext_reg <= req_data_i;
				default: delay_reg <= delay_reg;
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			for (int i = 0; i < `FBS_SLOTS; i++) slot_reg[i] <= 16'h0000;
		end else if (wr_ok && req_addr_i >= `FBS_PAR_SLOT0 &&
			req_addr_i <= `FBS_PAR_SLOT15) begin
			slot_reg[4'(req_addr_i - `FBS_PAR_SLOT0)] <= req_data_i;
		end
	end

	// frequency survives power loss through the external store
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			freq_reg <= `FBS_RST_FREQ;
		end else if (nv_load_i) begin
			freq_reg <= nv_freq_i;
		end else if (wr_ok && ((par_hit && req_addr_i == `FBS_PAR_FREQ) ||
			(win_hit && freq_src_serial_i &&
			req_addr_i[7:0] == `FBS_WIN_FREQ))) begin
			freq_reg <= req_data_i;
		end
	end

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ctrl_valid_o <= 1'b0;
			ctrl_index_o <= 8'h00;
			ctrl_data_o <= 16'h0000;
		end else begin
			ctrl_valid_o <= wr_ok && win_hit;
			if (wr_ok && win_hit) begin
				ctrl_index_o <= req_addr_i[7:0];
				ctrl_data_o <= req_data_i;
			end
		end
	end

	// ==========================================================
	// canopen / devicenet state, plc and reset strobes
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			co_warn_reg <= 16'h0000;
		end else begin
			// a new event beats a clear in the same cycle
			co_warn_reg <= (co_warn_clr_i ? 16'h0000 : co_warn_reg) |
				{9'h000, co_warn_evt_i[6:3], 1'b0,
				co_warn_evt_i[1:0]};
		end
	end

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			co_net_reg <= 16'h0000;
			co_prof_reg <= 16'h0000;
		end else begin
			co_net_reg <= {13'h0000, co_net_state_i};
			co_prof_reg <= {12'h000, co_prof_state_i};
		end
	end

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			plc_clr_freq_o <= 1'b0;
			plc_clr_torque_o <= 1'b0;
			plc_clr_limit_o <= 1'b0;
			co_grp_clear_o <= 4'h0;
		end else begin
			plc_clr_freq_o <= plc_scan_start_i && plc_mask_reg[0];
			plc_clr_torque_o <= plc_scan_start_i && plc_mask_reg[1];
			plc_clr_limit_o <= plc_scan_start_i && plc_mask_reg[2];
			co_grp_clear_o <= co_reset_i ? co_rstmsk_reg[3:0] : 4'h0;
		end
	end

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			co_rate_kbps_o <= 10'd1000;
			dn_rate_kbps_o <= 10'd500;
			co_std_profile_o <= 1'b1;
			comm_freq_o <= `FBS_RST_FREQ;
		end else begin
			co_std_profile_o <= co_dec_reg[0];
			comm_freq_o <= freq_reg;
			unique case (co_speed_reg[2:0])
				3'h0: co_rate_kbps_o <= 10'd1000;
				3'h1: co_rate_kbps_o <= 10'd500;
				3'h2: co_rate_kbps_o <= 10'd250;
				3'h3: co_rate_kbps_o <= 10'd125;
				3'h4: co_rate_kbps_o <= 10'd100;
				default: co_rate_kbps_o <= 10'd50;
			endcase
			if (!dn_ext_reg[0]) begin
				unique case (dn_speed_reg[1:0])
					2'h0: dn_rate_kbps_o <= 10'd125;
					2'h1: dn_rate_kbps_o <= 10'd250;
					2'h2: dn_rate_kbps_o <= 10'd500;
					default: dn_rate_kbps_o <= 10'd1000;
				endcase
			end else begin
				unique case (dn_speed_reg[3:0])
					4'h0: dn_rate_kbps_o <= 10'd10;
					4'h1: dn_rate_kbps_o <= 10'd20;
					4'h2: dn_rate_kbps_o <= 10'd50;
					4'h3: dn_rate_kbps_o <= 10'd100;
					4'h4: dn_rate_kbps_o <= 10'd125;
					4'h5: dn_rate_kbps_o <= 10'd250;
					4'h6: dn_rate_kbps_o <= 10'd500;
					4'h7: dn_rate_kbps_o <= 10'd800;
					default: dn_rate_kbps_o <= 10'd1000;
				endcase
			end
		end
	end

	// ==========================================================
	// reply body byte by index
	function automatic logic [7:0] body(input logic [5:0] i);
		logic [15:0] w;
		logic [7:0] v;
		w = rd_par(16'(rsp_base_reg + {11'h000, 5'(6'(i - 6'd3) >> 1)}));
		v = 8'h00;
		if (i == 6'd0) begin
			v = rsp_slave_reg;
		end else if (i == 6'd1) begin
			v = rsp_func_reg;
		end else if (rsp_exc_reg != `FBS_EXC_NONE) begin
			v = rsp_exc_reg;
		end else if (rsp_func_reg == `FBS_FN_WRITE_ONE) begin
			unique case (i[1:0])
				2'h2: v = rsp_base_reg[15:8];
				2'h3: v = rsp_base_reg[7:0];
				2'h0: v = rsp_data_reg[15:8];
				default: v = rsp_data_reg[7:0];
			endcase
		end else if (i == 6'd2) begin
			v = {rsp_cnt_reg[6:0], 1'b0};
		end else begin
			v = i[0] ? w[15:8] : w[7:0];
		end
		return v;
	endfunction

	fbs_frame_chk u_chk (
		.ref_clk_i(ref_clk_i),
		.arst_n_i(arst_n_i),
		.clr_i(take),
		.en_i(accept && tail_reg == FBS_TAIL_BODY),
		.byte_i(tx_byte_o),
		.crc_q_o(crc_q),
		.crc_n_o(crc_n),
		.lrc_n_o(lrc_n)
	);

	// ==========================================================
	// reply sequencer
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_reg <= FBS_IDLE;
			tail_reg <= FBS_TAIL_BODY;
			req_ready_o <= 1'b1;
			tx_valid_o <= 1'b0;
			tx_byte_o <= 8'h00;
			tx_last_o <= 1'b0;
			idx_reg <= 6'd0;
			plen_reg <= 6'd0;
			step_cnt_reg <= 16'h0000;
			tick_cnt_reg <= 16'h0000;
			rsp_slave_reg <= 8'h00;
			rsp_func_reg <= 8'h00;
			rsp_exc_reg <= 8'h00;
			rsp_base_reg <= 16'h0000;
			rsp_data_reg <= 16'h0000;
			rsp_cnt_reg <= 16'h0000;
			comm_error_display_o <= 8'h00;
		end else begin
			unique case (state_reg)
				FBS_IDLE: if (take) begin
					state_reg <= FBS_WAIT;
					req_ready_o <= 1'b0;
					step_cnt_reg <= 16'h0000;
					tick_cnt_reg <= 16'h0000;
					rsp_slave_reg <= req_slave_i;
					rsp_base_reg <= req_addr_i;
					rsp_data_reg <= req_data_i;
					rsp_cnt_reg <= req_data_i;
					rsp_exc_reg <= exc_next;
					comm_error_display_o <= exc_next;
					if (exc_next != `FBS_EXC_NONE) begin
						rsp_func_reg <= req_func_i | `FBS_FN_EXC_BIT;
						plen_reg <= 6'd3;
					end else if (req_func_i == `FBS_FN_WRITE_ONE) begin
						rsp_func_reg <= req_func_i;
						plen_reg <= 6'd6;
					end else begin
						rsp_func_reg <= req_func_i;
						plen_reg <= 6'(6'd3 + {req_data_i[4:0], 1'b0});
					end
				end
				FBS_WAIT: begin
					// whole 0.1 ms steps counted before the first byte
					if (tick_cnt_reg >= delay_reg) begin
						state_reg <= FBS_SEND;
						tail_reg <= FBS_TAIL_BODY;
						idx_reg <= 6'd0;
						tx_valid_o <= 1'b1;
						tx_byte_o <= body(6'd0);
					end else if (step_cnt_reg == 16'(STEP_CYC - 1)) begin
						step_cnt_reg <= 16'h0000;
						tick_cnt_reg <= 16'(tick_cnt_reg + 16'h0001);
					end else begin
						step_cnt_reg <= 16'(step_cnt_reg + 16'h0001);
					end
				end
				FBS_SEND: if (accept) begin
					if (tail_reg == FBS_TAIL_FINAL) begin
						state_reg <= FBS_IDLE;
						tx_valid_o <= 1'b0;
						tx_last_o <= 1'b0;
						req_ready_o <= 1'b1;
					end else if (tail_reg == FBS_TAIL_CRCLO) begin
						tail_reg <= FBS_TAIL_FINAL;
						tx_byte_o <= crc_q[15:8];
						tx_last_o <= 1'b1;
					end else if (idx_reg != 6'(plen_reg - 6'd1)) begin
						idx_reg <= 6'(idx_reg + 6'd1);
						tx_byte_o <= body(6'(idx_reg + 6'd1));
					end else if (rtu_mode_i) begin
						tail_reg <= FBS_TAIL_CRCLO;
						tx_byte_o <= crc_n[7:0];
					end else begin
						tail_reg <= FBS_TAIL_FINAL;
						tx_byte_o <= lrc_n;
						tx_last_o <= 1'b1;
					end
				end
				default: state_reg <= FBS_IDLE;
			endcase
		end
	end

endmodule

// ### tb/fbs_comm_sva.sv
`timescale 1ns/10ps
// ============================================================
// reply stream and side pulse checks
module fbs_comm_sva #(
	parameter int STEP_CYC = 4
)
(
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	input wire logic req_valid_i,
	input wire logic req_ready_o,
	input wire logic tx_valid_o,
	input wire logic [7:0] tx_byte_o,
	input wire logic tx_last_o,
	input wire logic tx_ready_i,
	input wire logic ctrl_valid_o,
	input wire logic plc_scan_start_i,
	input wire logic plc_clr_freq_o,
	input wire logic plc_clr_torque_o,
	input wire logic plc_clr_limit_o,
	input wire logic co_reset_i,
	input wire logic [3:0] co_grp_clear_o,
	input wire logic [9:0] co_rate_kbps_o,
	input wire logic [9:0] dn_rate_kbps_o,
	input wire logic [7:0] comm_error_display_o
);
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!arst_n_i);
	logic take;
	assign take = req_valid_i && req_ready_o;
	busy_after_take_a: assert property (
		take |=> !req_ready_o && !tx_valid_o)
		else $error("reply or ready too early after take");
	idle_no_tx_a: assert property (
		req_ready_o |-> !tx_valid_o)
		else $error("byte offered while idle");
	byte_hold_a: assert property (
		tx_valid_o && !tx_ready_i |=>
		tx_valid_o && $stable(tx_byte_o) && $stable(tx_last_o))
		else $error("reply byte changed before accept");
	frame_end_a: assert property (
		tx_valid_o && tx_ready_i && tx_last_o |=>
		!tx_valid_o && !tx_last_o && req_ready_o)
		else $error("frame did not close after last byte");
	plc_quiet_a: assert property (
		!plc_scan_start_i |=>
		!(plc_clr_freq_o || plc_clr_torque_o || plc_clr_limit_o))
		else $error("plc clear without scan start");
	grp_quiet_a: assert property (
		!co_reset_i |=> co_grp_clear_o == 4'h0)
		else $error("group clear without canopen reset");
	ctrl_cause_a: assert property (
		ctrl_valid_o |-> $past(take))
		else $error("control write without a taken request");
	co_rate_a: assert property (
		co_rate_kbps_o inside {1000, 500, 250, 125, 100, 50})
		else $error("canopen rate outside the code table");
	dn_rate_a: assert property (
		dn_rate_kbps_o inside {10, 20, 50, 100, 125, 250, 500, 800, 1000})
		else $error("devicenet rate outside the code table");
	err_code_a: assert property (
		comm_error_display_o <= 8'h04)
		else $error("error display outside codes 0 to 4");
	cover property (take ##1 !req_ready_o);
	cover property (tx_valid_o && tx_ready_i && tx_last_o);
	cover property (plc_scan_start_i ##1 plc_clr_freq_o);
	cover property (co_reset_i ##1 co_grp_clear_o != 4'h0);
endmodule

bind fbs_comm fbs_comm_sva #(.STEP_CYC(STEP_CYC)) fbs_comm_sva_inst (.*);

// ### tb/fbs_master_model.sv
`timescale 1ns/10ps
// ============================================================
// bus master side: takes reply bytes, stalls one cycle in three
module fbs_master_model (
	input wire logic clk_i,
	input wire logic valid_i,
	input wire logic [7:0] byte_i,
	input wire logic last_i,
	output logic ready_o
);
	logic [7:0] rx[$];
	int frames = 0;
	logic [1:0] tick = 2'h0;
	initial ready_o = 1'b0;
	// stalls keep held bytes under test
	always @(negedge clk_i) begin
		tick <= tick == 2'h2 ? 2'h0 : tick + 2'h1;
		ready_o <= tick != 2'h0;
	end
	// whole reply gathered, checked by the bench
	always @(posedge clk_i) begin
		if (valid_i === 1'b1 && ready_o === 1'b1) begin
			rx.push_back(byte_i);
			if (last_i === 1'b1)
				frames <= frames + 1;
		end
	end
endmodule

// ### tb/fbs_comm_tb.sv
`timescale 1ns/10ps
`include "fbs_defs.svh"
// ============================================================
// bench top
module fbs_comm_tb;
	logic ref_clk_i = 1'b0, arst_n_i = 1'b0, rtu_mode_i = 1'b1;
	logic req_valid_i = 1'b0, req_exec_fail_i = 1'b0, tx_ready_i;
	logic [7:0] req_slave_i = 8'h11, req_func_i = 8'h00;
	logic [15:0] req_addr_i = 16'h0000, req_data_i = 16'h0000;
	logic freq_src_serial_i = 1'b1, nv_load_i = 1'b0;
	logic [15:0] nv_freq_i = 16'h0000;
	logic plc_scan_start_i = 1'b0, co_warn_clr_i = 1'b0, co_reset_i = 1'b0;
	logic [6:0] co_warn_evt_i = 7'h00;
	logic [2:0] co_net_state_i = 3'h0;
	logic [3:0] co_prof_state_i = 4'h0;
	logic req_ready_o, tx_valid_o, tx_last_o, ctrl_valid_o;
	logic [7:0] tx_byte_o, ctrl_index_o, comm_error_display_o;
	logic [15:0] comm_freq_o, ctrl_data_o;
	logic plc_clr_freq_o, plc_clr_torque_o, plc_clr_limit_o, co_std_profile_o;
	logic [3:0] co_grp_clear_o;
	logic [9:0] co_rate_kbps_o, dn_rate_kbps_o;
	int mismatches = 0, tests_run = 0, dly = 20, ctrl_seen = 0;
	logic [7:0] body[$];
	fbs_comm #(.STEP_CYC(4)) fbs_comm_inst (.*);
	fbs_master_model fbs_master_model_inst (.clk_i(ref_clk_i),
		.valid_i(tx_valid_o), .byte_i(tx_byte_o), .last_i(tx_last_o),
		.ready_o(tx_ready_i));
	initial begin
		forever #2 ref_clk_i = ~ref_clk_i;
	end
	always @(posedge ref_clk_i) begin
		if (ctrl_valid_o === 1'b1)
			ctrl_seen <= ctrl_seen + 1;
	end
	task automatic chk(input logic [63:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	function automatic logic [15:0] crc16(input logic [7:0] q[$]);
		logic [15:0] c;
		c = 16'hffff;
		foreach (q[i]) begin
			c = c ^ q[i];
			for (int k = 0; k < 8; k++)
				c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
		end
		return c;
	endfunction
	function automatic logic [7:0] lrc8(input logic [7:0] q[$]);
		logic [7:0] s;
		s = 8'h00;
		foreach (q[i])
			s = s + q[i];
		return -s;
	endfunction
	// one request, whole reply gathered, latency and check bytes judged
	task automatic xact(input logic [7:0] fn, input logic [15:0] ad, dt,
		input logic fl);
		int n;
		int f0;
		logic [15:0] c;
		n = 1;
		f0 = fbs_master_model_inst.frames;
		fbs_master_model_inst.rx.delete();
		chk(req_ready_o, 1);
		req_func_i = fn;
		req_addr_i = ad;
		req_data_i = dt;
		req_exec_fail_i = fl;
		req_valid_i = 1'b1;
		@(negedge ref_clk_i);
		req_valid_i = 1'b0;
		while (tx_valid_o !== 1'b1 && n < 3000) begin
			@(negedge ref_clk_i);
			n++;
		end
		if (ad !== `FBS_PAR_DELAY)
			chk(n, dly * 4 + 2);
		n = 0;
		while (fbs_master_model_inst.frames == f0 && n < 3000) begin
			@(negedge ref_clk_i);
			n++;
		end
		if (n == 3000) begin
			mismatches++;
			conclude();
		end
		@(negedge ref_clk_i);
		body = fbs_master_model_inst.rx;
		c = body.pop_back();
		if (rtu_mode_i) begin
			c = {c[7:0], body.pop_back()};
			chk(c, crc16(body));
		end else
			chk(c, lrc8(body));
		chk(body[0], 8'h11);
	endtask
	task automatic exc(input logic [7:0] fn, input logic [15:0] ad, dt,
		input logic fl, input logic [7:0] code);
		xact(fn, ad, dt, fl);
		chk(body.size(), 3);
		chk(body[1], fn | `FBS_FN_EXC_BIT);
		chk(body[2], code);
		chk(comm_error_display_o, code);
	endtask
	task automatic wr(input logic [15:0] ad, dt);
		xact(`FBS_FN_WRITE_ONE, ad, dt, 1'b0);
		chk({body[1], body[2], body[3], body[4], body[5]},
			{8'h06, ad, dt});
		chk(comm_error_display_o, 8'h00);
		if (ad == `FBS_PAR_DELAY)
			dly = dt;
	endtask
	task automatic rd(input logic [15:0] ad, n);
		xact(`FBS_FN_READ_HOLD, ad, n, 1'b0);
		chk(body[2], 2 * n);
	endtask
	function automatic logic [15:0] wd(input int i);
		return {body[3 + 2 * i], body[4 + 2 * i]};
	endfunction
	task automatic t_exc();
		logic [47:0] t[6] = '{48'h07_0909_0001_01, 48'h03_0909_0000_03,
			48'h03_0800_0001_02, 48'h03_0924_0002_02, 48'h06_091e_0000_04,
			48'h06_0909_07d1_03};
		chk({req_ready_o, comm_freq_o, co_rate_kbps_o, dn_rate_kbps_o,
			co_std_profile_o}, {1'b1, 16'h1770, 10'd1000, 10'd500, 1'b1});
		for (int i = 0; i < 6; i++)
			exc(t[i][47:40], t[i][39:24], t[i][23:8], 1'b0, t[i][7:0]);
		exc(8'h06, 16'h0910, 16'h0001, 1'b1, 8'h04);
		$display("reset and exceptions done");
	endtask
	task automatic t_slots();
		rtu_mode_i = 1'b0;
		wr(`FBS_PAR_DELAY, 16'h0001);
		wr(`FBS_PAR_SLOT0, 16'ha5a5);
		wr(`FBS_PAR_SLOT15, 16'h0102);
		rd(`FBS_PAR_SLOT0, 16'h0010);
		for (int i = 0; i < 16; i++)
			chk(wd(i), i == 0 ? 16'ha5a5 : i == 15 ? 16'h0102 : 16'h0);
		rtu_mode_i = 1'b1;
		$display("block slots done");
	endtask
	task automatic t_freq();
		int s;
		wr(`FBS_PAR_FREQ, 16'h1234);
		chk(comm_freq_o, 16'h1234);
		nv_freq_i = 16'h0bb8;
		nv_load_i = 1'b1;
		@(negedge ref_clk_i);
		nv_load_i = 1'b0;
		@(negedge ref_clk_i);
		chk(comm_freq_o, 16'h0bb8);
		s = ctrl_seen;
		wr(16'h6001, 16'h0fa0);
		chk({ctrl_index_o, ctrl_data_o, comm_freq_o}, 40'h010fa00fa0);
		wr(`FBS_PAR_DEC_METH, 16'h0000);
		exc(8'h06, 16'h6001, 16'h0100, 1'b0, 8'h02);
		exc(8'h06, 16'h2001, 16'he9fd, 1'b0, 8'h03);
		wr(16'h2001, 16'he9fc);
		chk(comm_freq_o, 16'he9fc);
		freq_src_serial_i = 1'b0;
		wr(16'h2001, 16'h0300);
		chk(comm_freq_o, 16'he9fc);
		chk(ctrl_seen, s + 3);
		freq_src_serial_i = 1'b1;
		$display("frequency and windows done");
	endtask
	task automatic t_pulses();
		logic [2:0] m[2] = '{3'h5, 3'h2};
		for (int i = 0; i < 2; i++) begin
			wr(`FBS_PAR_PLC_MASK, 16'(m[i]));
			plc_scan_start_i = 1'b1;
			@(negedge ref_clk_i);
			plc_scan_start_i = 1'b0;
			chk({plc_clr_limit_o, plc_clr_torque_o, plc_clr_freq_o}, m[i]);
			if (i == 1)
				wr(`FBS_PAR_CO_RSTMSK, 16'h0009);
			co_reset_i = 1'b1;
			@(negedge ref_clk_i);
			co_reset_i = 1'b0;
			chk(co_grp_clear_o, i == 0 ? 4'hf : 4'h9);
		end
		$display("plc and group clears done");
	endtask
	task automatic t_canopen();
		int co[6] = '{1000, 500, 250, 125, 100, 50};
		int dn[13] = '{125, 250, 500, 1000, 10, 20, 50, 100, 125, 250, 500,
			800, 1000};
		for (int i = 0; i < 2; i++) begin
			co_warn_evt_i = i == 0 ? 7'h7f : 7'h00;
			co_warn_clr_i = i == 1;
			@(negedge ref_clk_i);
			co_warn_evt_i = 7'h00;
			co_warn_clr_i = 1'b0;
			rd(`FBS_PAR_CO_WARN, 16'h0001);
			chk(wd(0), i == 0 ? 16'h007b : 16'h0000);
		end
		for (int i = 0; i < 6; i++) begin
			wr(`FBS_PAR_CO_SPEED, 16'(i));
			chk(co_rate_kbps_o, co[i]);
		end
		exc(8'h06, `FBS_PAR_CO_SPEED, 16'h0006, 1'b0, 8'h03);
		for (int i = 0; i < 13; i++) begin
			if (i == 4) begin
				exc(8'h06, `FBS_PAR_DN_SPEED, 16'h0004, 1'b0, 8'h03);
				wr(`FBS_PAR_DN_EXT, 16'h0001);
			end
			wr(`FBS_PAR_DN_SPEED, i < 4 ? 16'(i) : 16'(i - 4));
			chk(dn_rate_kbps_o, dn[i]);
		end
		wr(`FBS_PAR_CO_DEC, 16'h0000);
		chk(co_std_profile_o, 0);
		co_net_state_i = 3'h5;
		co_prof_state_i = 4'he;
		rd(`FBS_PAR_CO_NET, 16'h0002);
		chk({wd(0), wd(1)}, 32'h0005000e);
		exc(8'h06, `FBS_PAR_CO_NET, 16'h0001, 1'b0, 8'h04);
		$display("canopen and devicenet done");
	endtask
	initial begin
		repeat (16) @(negedge ref_clk_i);
		arst_n_i = 1'b1;
		t_exc();
		t_slots();
		t_freq();
		t_pulses();
		t_canopen();
		conclude();
	end
endmodule
